// >>> src/ict_pkg.sv
// package: encodings, field positions and reset values of the instruction timing core
package ict_pkg;
	localparam int          ICYC_CLKS  = 4;        // system clocks per instruction cycle
	localparam int          IW         = 16;       // instruction word width
	localparam int          DW         = 8;        // data width
	// instruction word fields
	localparam int          F_OP_HI    = 15;
	localparam int          F_OP_LO    = 12;
	localparam int          F_DEST     = 11;       // 1: result to data memory
	localparam int          F_SEL_HI   = 10;       // alu op, rotate kind or bit index
	localparam int          F_SEL_LO   = 8;
	localparam int          F_ARG_HI   = 7;        // data address or immediate
	localparam int          F_TGT_HI   = 11;       // jump target field
	// operation codes
	localparam logic [3:0]  OP_NOP     = 4'h0;
	localparam logic [3:0]  OP_MOVX    = 4'h1;     // acc = immediate
	localparam logic [3:0]  OP_ALUM    = 4'h2;     // acc op memory
	localparam logic [3:0]  OP_ALUX    = 4'h3;     // acc op immediate
	localparam logic [3:0]  OP_MOVM    = 4'h4;     // memory = acc
	localparam logic [3:0]  OP_ROT     = 4'h5;
	localparam logic [3:0]  OP_BSET    = 4'h6;
	localparam logic [3:0]  OP_BCLR    = 4'h7;
	localparam logic [3:0]  OP_SZ      = 4'h8;     // skip if byte zero
	localparam logic [3:0]  OP_SZB     = 4'h9;     // skip if bit zero
	localparam logic [3:0]  OP_JMP     = 4'hA;
	localparam logic [3:0]  OP_CALL    = 4'hB;
	localparam logic [3:0]  OP_RET     = 4'hC;
	localparam logic [3:0]  OP_RETURN_FROM_IRQ_INSTR    = 4'hD;
	localparam logic [3:0]  OP_TBRD    = 4'hE;     // table read into acc
	// alu selects
	localparam logic [2:0]  ALU_ADD    = 3'h0;
	localparam logic [2:0]  ALU_ADC    = 3'h1;
	localparam logic [2:0]  ALU_SUB    = 3'h2;
	localparam logic [2:0]  ALU_SBC    = 3'h3;
	localparam logic [2:0]  ALU_AND    = 3'h4;
	localparam logic [2:0]  ALU_OR     = 3'h5;
	localparam logic [2:0]  ALU_XOR    = 3'h6;
	localparam logic [2:0]  ALU_CPL    = 3'h7;
	// rotate selects
	localparam logic [2:0]  ROTATE_RIGHT               = 3'h0;
	localparam logic [2:0]  ROTATE_LEFT                = 3'h1;
	localparam logic [2:0]  ROTATE_RIGHT_THROUGH_CARRY = 3'h2;
	localparam logic [2:0]  ROTATE_LEFT_THROUGH_CARRY  = 3'h3;
	// data address that aliases the program counter low byte
	localparam logic [7:0]  PROGRAM_COUNTER_LOW_BYTE   = 8'h02;
	// fast oscillator option codes
	localparam logic [1:0]  FOSC_8MHZ  = 2'h0;
	localparam logic [1:0]  FOSC_12MHZ = 2'h1;
	localparam logic [1:0]  FOSC_16MHZ = 2'h2;
	// reset values
	localparam int          PC_RST     = 0;
	localparam logic [7:0]  ACC_RST    = 8'h00;
	localparam logic [15:0] IR_RST     = 16'h0000;
	localparam logic        FLAG_RST   = 1'b0;
	localparam logic        GIE_RST    = 1'b0;
	typedef enum logic [1:0] {PH_FETCH, PH_READ, PH_CALC, PH_COMMIT} ict_phase_e;
endpackage

// >>> src/ict_stack.sv
// return address stack memory with registered read data
`timescale 1ns/10ps
module ict_stack #(
	parameter int W  = 12,
	parameter int D  = 8,
	parameter int AW = $clog2(D)
) (
	input  wire logic          clk,   // system clock
	input  wire logic          we,    // write strobe
	input  wire logic [AW-1:0] waddr, // write slot
	input  wire logic [W-1:0]  wdata, // return address
	input  wire logic [AW-1:0] raddr, // read slot
	output logic      [W-1:0]  rdata  // registered top of stack
);
	logic [W-1:0] mem [D];

	// no reset on the array; the read port settles one clock after the pointer moves
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
		rdata <= mem[raddr];
	end
endmodule // ict_stack

// >>> src/ict_core.sv
// instruction sequencing and timing core with data and program memory ports
`timescale 1ns/10ps
// Behaviour
// - every instruction cycle lasts exactly four system clocks and timing counts in cycles.
// - an instruction outside the extra-cycle classes finishes in one instruction cycle.
// - jump, call, return, return-from-interrupt and table read take two cycles.
// - a write to the program counter low byte acts as a jump and costs one more cycle.
// - a skip test costs one extra cycle when it skips and one cycle when it does not.
// - a conditional skip tests a data byte or one of its bits and skips the next word.
// - a call saves the address after it for the return, and a jump saves nothing.
// - and, or, xor and complement set the zero flag when their result is zero.
// - rotates move one bit left or right, and the through-carry forms pass it via carry.
// - add reports carry above 255 and subtract reports borrow below zero.
// - bit set and clear read the byte, change only that bit and write it back.
// - a table read fetches a constant from program memory and returns it to the program.
// - the fast oscillator frequency is fixed at configuration and software cannot change it.
// - return-from-interrupt restores the pc and sets the global enable, return leaves it.
module ict_core import ict_pkg::*; #(
	parameter int PC_W  = 12,
	parameter int STK_D = 8
) (
	input  wire logic            CLK,                          // system clock
	input  wire logic            RST_N,                        // async reset, low
	output logic      [PC_W-1:0] PM_ADDR,                      // program memory address
	input  wire logic [IW-1:0]   PM_DATA,                      // program word for PM_ADDR
	output logic      [7:0]      DM_ADDR,                      // data memory address
	input  wire logic [DW-1:0]   DM_RDATA,                     // data read for DM_ADDR
	output logic      [DW-1:0]   DM_WDATA,                     // data to write
	output logic                 DM_WE,                        // write, phase four
	input  wire logic [1:0]      FOSC_OPTION,                  // configuration option
	output logic      [1:0]      FAST_INTERNAL_OSCILLATOR_SEL, // frozen frequency code
	input  wire logic            IRQ_ACK,                      // clears global enable
	output logic                 GLOBAL_IRQ_ENABLE,            // global interrupt enable
	output logic      [DW-1:0]   ACC,                          // accumulator
	output logic                 FLAG_C,                       // carry / borrow
	output logic                 FLAG_Z                        // zero
);
	localparam int AW = $clog2(STK_D);

	ict_phase_e      ph_r, ph_nxt;
	logic [IW-1:0]   ir_r, ir_nxt;
	logic            vld_r, vld_nxt, tbl_r, tbl_nxt;
	logic [PC_W-1:0] pc_r, pc_nxt, pma_r, pma_nxt;
	logic [DW-1:0]   acc_r, acc_nxt, mrd_r, mrd_nxt, dwd_r, dwd_nxt;
	logic [7:0]      dma_r, dma_nxt;
	logic            c_r, c_nxt, z_r, z_nxt, dwe_r, dwe_nxt, gie_r, gie_nxt;
	logic [AW-1:0]   sp_r, sp_nxt;
	logic [1:0]      fosc_r, fosc_nxt;
	logic            fcap_r, fcap_nxt;
	logic [PC_W-1:0] stk_rd, tgt;
	logic [3:0]      op;
	logic [2:0]      sel;
	logic [7:0]      arg, opd;
	logic [DW:0]     sum;
	logic [DW-1:0]   res;
	logic            ex, cy, zf, wmem, wacc, skip, jump_instr, push, pop, tbl, seti, cyc_end;

	function automatic logic [7:0] bit_mask(input logic [2:0] idx);
		return 8'h01 << idx;
	endfunction

	// reference result of the logic group, kept apart from the datapath for the zero check
	function automatic logic [7:0] logic_ref(input logic [2:0] s, input logic [7:0] a,
		input logic [7:0] b);
		return (s == ALU_AND) ? (a & b) : (s == ALU_OR) ? (a | b) : (s == ALU_XOR) ? (a ^ b) : ~b;
	endfunction

	assign op      = ir_r[F_OP_HI:F_OP_LO];
	assign sel     = ir_r[F_SEL_HI:F_SEL_LO];
	assign arg     = ir_r[F_ARG_HI:0];
	assign ex      = vld_r && !tbl_r;              // a real instruction, not a bubble
	assign cyc_end = (ph_r == PH_COMMIT);

	ict_stack #(.W(PC_W), .D(STK_D)) u_stack (
		.clk   (CLK),
		.we    (cyc_end && ex && push),
		.waddr (sp_r),
		.wdata (pc_r),
		.raddr (sp_r - 1'b1),
		.rdata (stk_rd)
	);

	// execute: results are stable from the calc phase until the commit edge
	always_comb begin
		opd  = (op == OP_ALUM) ? mrd_r : arg;
		sum  = 9'h000;
		res  = acc_r;
		cy   = c_r;
		zf   = z_r;
		wmem = 1'b0;
		wacc = 1'b0;
		skip = 1'b0;
		jump_instr  = 1'b0;
		tgt  = pc_r;
		push = 1'b0;
		pop  = 1'b0;
		tbl  = 1'b0;
		seti = 1'b0;
		if (ex) begin
			case (op)
				OP_MOVX: begin
					res  = arg;
					wacc = 1'b1;
				end
				OP_ALUM, OP_ALUX: begin
					unique case (sel)
						ALU_ADD: sum = {1'b0, acc_r} + {1'b0, opd};
						ALU_ADC: sum = {1'b0, acc_r} + {1'b0, opd} + {8'h00, c_r};
						ALU_SUB: sum = {1'b0, acc_r} - {1'b0, opd};
						ALU_SBC: sum = {1'b0, acc_r} - {1'b0, opd} - {8'h00, c_r};
						ALU_AND: sum = {1'b0, acc_r & opd};
						ALU_OR:  sum = {1'b0, acc_r | opd};
						ALU_XOR: sum = {1'b0, acc_r ^ opd};
						ALU_CPL: sum = {1'b0, ~opd};
					endcase
					res = sum[DW-1:0];
					zf  = (res == 8'h00);
					if (sel < ALU_AND) begin
						cy = sum[DW];          // carry out, or borrow for subtract
					end
					wmem = ir_r[F_DEST] && (op == OP_ALUM);
					wacc = !wmem;
				end
				OP_MOVM: begin
					wmem = 1'b1;
				end
				OP_ROT: begin
					unique case (sel)
						ROTATE_RIGHT: res = {mrd_r[0], mrd_r[7:1]};
						ROTATE_LEFT:  res = {mrd_r[6:0], mrd_r[7]};
						ROTATE_RIGHT_THROUGH_CARRY: begin
							res = {c_r, mrd_r[7:1]};
							cy  = mrd_r[0];
						end
						ROTATE_LEFT_THROUGH_CARRY: begin
							res = {mrd_r[6:0], c_r};
							cy  = mrd_r[7];
						end
						default: res = mrd_r;  // spare selects pass the byte unchanged
					endcase
					wmem = ir_r[F_DEST];
					wacc = !ir_r[F_DEST];
				end
				OP_BSET: begin
					res  = mrd_r | bit_mask(sel);
					wmem = 1'b1;
				end
				OP_BCLR: begin
					res  = mrd_r & ~bit_mask(sel);
					wmem = 1'b1;
				end
				OP_SZ:  skip = (mrd_r == 8'h00);
				OP_SZB: skip = ((mrd_r & bit_mask(sel)) == 8'h00);
				OP_JMP: begin
					jump_instr = 1'b1;
					tgt = PC_W'(ir_r[F_TGT_HI:0]);
				end
				OP_CALL: begin
					jump_instr  = 1'b1;
					push = 1'b1;               // pc_r already points past the call
					tgt  = PC_W'(ir_r[F_TGT_HI:0]);
				end
				OP_RET, OP_RETURN_FROM_IRQ_INSTR: begin
					jump_instr  = 1'b1;
					pop  = 1'b1;
					tgt  = stk_rd;
					seti = (op == OP_RETURN_FROM_IRQ_INSTR);
				end
				OP_TBRD: tbl = 1'b1;
				default: ;                     // unused codes behave as no operation
			endcase
			if (wmem && arg == PROGRAM_COUNTER_LOW_BYTE) begin
				jump_instr = 1'b1;
				tgt = {pc_r[PC_W-1:8], res};
			end
		end
	end

	// sequencer: fetch, read, calc, commit; the next word is prefetched in parallel
	always_comb begin
		ph_nxt   = ph_r;
		ir_nxt   = ir_r;
		vld_nxt  = vld_r;
		tbl_nxt  = tbl_r;
		pc_nxt   = pc_r;
		pma_nxt  = pma_r;
		acc_nxt  = acc_r;
		mrd_nxt  = mrd_r;
		dwd_nxt  = dwd_r;
		dma_nxt  = dma_r;
		dwe_nxt  = 1'b0;
		c_nxt    = c_r;
		z_nxt    = z_r;
		sp_nxt   = sp_r;
		fosc_nxt = fosc_r;
		fcap_nxt = 1'b1;
		gie_nxt  = gie_r;
		// the option is caught once after reset and frozen from then on
		if (!fcap_r) begin
			fosc_nxt = (FOSC_OPTION == FOSC_16MHZ || FOSC_OPTION == FOSC_12MHZ) ?
				FOSC_OPTION : FOSC_8MHZ;
		end
		if (IRQ_ACK) begin
			gie_nxt = 1'b0;
		end
		unique case (ph_r)
			PH_FETCH: begin
				ph_nxt  = PH_READ;
				dma_nxt = arg;
			end
			PH_READ: begin
				ph_nxt  = PH_CALC;
				mrd_nxt = DM_RDATA;    // read half of read-modify-write
			end
			PH_CALC: begin
				ph_nxt  = PH_COMMIT;
				dwe_nxt = wmem;        // write strobe covers the commit phase
				dwd_nxt = res;
			end
			PH_COMMIT: begin
				ph_nxt = PH_FETCH;
				if (tbl_r) begin
					acc_nxt = PM_DATA[DW-1:0];  // second cycle of a table read
					tbl_nxt = 1'b0;
					pma_nxt = pc_r;
				end else begin
					ir_nxt  = PM_DATA;
					vld_nxt = 1'b1;
					pc_nxt  = pc_r + 1'b1;
					if (wacc) begin
						acc_nxt = res;
					end
					c_nxt = cy;
					z_nxt = zf;
					if (skip || jump_instr) begin
						vld_nxt = 1'b0;    // fetched word discarded, bubble
					end
					if (jump_instr) begin
						pc_nxt = tgt;
					end
					if (push) begin
						sp_nxt = sp_r + 1'b1;
					end
					if (pop) begin
						sp_nxt = sp_r - 1'b1;
					end
					if (seti) begin
						gie_nxt = 1'b1;    // set wins over a same-cycle ack
					end
					tbl_nxt = tbl;
					pma_nxt = tbl ? PC_W'({ir_r[F_SEL_HI+1:F_SEL_LO], acc_r}) : pc_nxt;
				end
			end
		endcase
	end

	always_ff @(posedge CLK or negedge RST_N) begin
		if (!RST_N) begin
			ph_r   <= PH_FETCH;
			ir_r   <= IR_RST;
			vld_r  <= 1'b0;            // first cycle is a bubble fetching the reset pc
			tbl_r  <= 1'b0;
			pc_r   <= PC_W'(PC_RST);
			pma_r  <= PC_W'(PC_RST);
			acc_r  <= ACC_RST;
			mrd_r  <= 8'h00;
			dwd_r  <= 8'h00;
			dma_r  <= 8'h00;
			dwe_r  <= 1'b0;
			c_r    <= FLAG_RST;
			z_r    <= FLAG_RST;
			sp_r   <= '0;
			fosc_r <= FOSC_8MHZ;
			fcap_r <= 1'b0;
			gie_r  <= GIE_RST;
		end else begin
			ph_r   <= ph_nxt;
			ir_r   <= ir_nxt;
			vld_r  <= vld_nxt;
			tbl_r  <= tbl_nxt;
			pc_r   <= pc_nxt;
			pma_r  <= pma_nxt;
			acc_r  <= acc_nxt;
			mrd_r  <= mrd_nxt;
			dwd_r  <= dwd_nxt;
			dma_r  <= dma_nxt;
			dwe_r  <= dwe_nxt;
			c_r    <= c_nxt;
			z_r    <= z_nxt;
			sp_r   <= sp_nxt;
			fosc_r <= fosc_nxt;
			fcap_r <= fcap_nxt;
			gie_r  <= gie_nxt;
		end
	end

	assign PM_ADDR                      = pma_r;
	assign DM_ADDR                      = dma_r;
	assign DM_WDATA                     = dwd_r;
	assign DM_WE                        = dwe_r;
	assign FAST_INTERNAL_OSCILLATOR_SEL = fosc_r;
	assign GLOBAL_IRQ_ENABLE            = gie_r;
	assign ACC                          = acc_r;
	assign FLAG_C                       = c_r;
	assign FLAG_Z                       = z_r;

	// checks on cycle timing, flow and flags
	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RST_N);

	a_cycle_four_clk: assert property (cyc_end |=> (!cyc_end)[*3] ##1 cyc_end)
		else $error("instruction cycle not four clocks");
	a_plain_one_cyc: assert property (cyc_end && ex && !jump_instr && !skip && !tbl |=> vld_r && !tbl_r)
		else $error("plain instruction took an extra cycle");
	a_jump_bubble: assert property (cyc_end && ex && jump_instr |=> (!vld_r)[*4] ##1 vld_r)
		else $error("redirect bubble wrong length");
	a_table_two_cyc: assert property (cyc_end && ex && tbl |=> tbl_r[*4] ##1 !tbl_r)
		else $error("table read not two cycles");
	a_pcl_write_jump: assert property (cyc_end && ex && wmem && arg == PROGRAM_COUNTER_LOW_BYTE
		|=> pc_r[7:0] == $past(res) && !vld_r)
		else $error("pc low byte write did not redirect");
	a_skip_taken: assert property (cyc_end && ex && skip |=> (!vld_r)[*4] ##1 vld_r)
		else $error("taken skip not two cycles");
	a_skip_pc_step: assert property (cyc_end && ex && skip |=> pc_r == $past(pc_r) + 1'b1)
		else $error("skip did not pass over next word");
	a_call_push: assert property (cyc_end && ex && op == OP_CALL |=> sp_r == $past(sp_r) + 1'b1)
		else $error("call did not save return point");
	a_jump_no_push: assert property (cyc_end && ex && op == OP_JMP |=> $stable(sp_r))
		else $error("jump touched the stack");
	a_zero_logic: assert property (cyc_end && ex && (op == OP_ALUM || op == OP_ALUX) && sel >= ALU_AND
		&& !jump_instr |=> z_r == (logic_ref($past(sel), $past(acc_r), $past(opd)) == 8'h00))
		else $error("zero flag wrong after logic op");
	a_rrc_carry: assert property (cyc_end && ex && op == OP_ROT && sel == ROTATE_RIGHT_THROUGH_CARRY
		|=> c_r == $past(mrd_r[0]))
		else $error("rotate through carry lost bit");
	a_add_carry: assert property (cyc_end && ex && (op == OP_ALUM || op == OP_ALUX) && sel == ALU_ADD
		|=> c_r == (({1'b0, $past(acc_r)} + {1'b0, $past(opd)}) > 9'h0FF))
		else $error("add carry wrong");
	a_bit_rmw_only: assert property (DM_WE && ex && (op == OP_BSET || op == OP_BCLR)
		|-> ((DM_WDATA ^ mrd_r) & ~bit_mask(sel)) == 8'h00)
		else $error("bit op changed other bits");
	a_osc_frozen: assert property (fcap_r |=> $stable(fosc_r))
		else $error("oscillator select changed");
	a_return_from_irq_instr_enable: assert property (cyc_end && ex && op == OP_RETURN_FROM_IRQ_INSTR |=> gie_r)
		else $error("return from interrupt left enable low");
	a_ret_keeps: assert property (cyc_end && ex && op == OP_RET && !IRQ_ACK |=> gie_r == $past(gie_r))
		else $error("plain return changed enable");

	c_call_seen: cover property (cyc_end && ex && op == OP_CALL);
	c_skip_taken: cover property (cyc_end && ex && skip);
	c_table_read: cover property (cyc_end && tbl_r);
	c_return_from_irq_instr_seen: cover property (cyc_end && ex && op == OP_RETURN_FROM_IRQ_INSTR);
endmodule // ict_core

// >>> tb/ict_mem_model.sv
// program and data memory model standing at the far side of the core
`timescale 1ns/10ps
module ict_mem_model import ict_pkg::*; (
	input  wire logic [11:0]   PM_ADDR,  // program address
	output logic      [IW-1:0] PM_DATA,  // program word
	input  wire logic          CLK,      // system clock
	input  wire logic [7:0]    DM_ADDR,  // data address
	output logic      [DW-1:0] DM_RDATA, // data read
	input  wire logic [DW-1:0] DM_WDATA, // data to write
	input  wire logic          DM_WE     // write strobe
);
	logic [IW-1:0] pm [4096]; // loaded by the bench before each run
	logic [DW-1:0] dm [256];  // loaded by the bench, then written by the core
	// combinational reads, so the word is settled long before the sampling edge
	assign PM_DATA  = pm[PM_ADDR];
	assign DM_RDATA = dm[DM_ADDR];
	// the write lands on the edge that closes the strobe clock
	always @(posedge CLK) begin
		if (DM_WE) begin
			dm[DM_ADDR] <= DM_WDATA;
		end
	end
endmodule // ict_mem_model

// >>> tb/test_cpu_instruction_timing.sv
// bench: random programs run on the core and on an instruction-level model
`timescale 1ns/10ps
`define CHK(got, exp, what) \
	begin \
		checks++; \
		if ((got) !== (exp)) begin \
			error_cnt++; \
			$display("MISMATCH t=%0t %s got %0h exp %0h", $time, what, got, (exp)); \
		end \
	end
module test_cpu_instruction_timing import ict_pkg::*;;
	typedef struct {int acc, c, z, g, pm, wa, wd, ack;} ict_exp_s;
	logic        CLK, RST_N, IRQ_ACK, DM_WE, GLOBAL_IRQ_ENABLE, FLAG_C, FLAG_Z;
	logic [1:0]  FOSC_OPTION, FAST_INTERNAL_OSCILLATOR_SEL;
	logic [11:0] PM_ADDR;
	logic [15:0] PM_DATA;
	logic [7:0]  DM_ADDR, DM_RDATA, DM_WDATA, ACC;
	int          error_cnt = 0;
	int          checks = 0;
	int          acc, cf, zf, gie, pc, ack_c, opt;
	int          stk[$];
	ict_exp_s    exp_q[$];
	logic [15:0] mdl_pm [4096];
	int          mdl_dm [256];

	ict_core #(.PC_W(12), .STK_D(8)) dut (
		.CLK(CLK), .RST_N(RST_N), .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA),
		.DM_ADDR(DM_ADDR), .DM_RDATA(DM_RDATA), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE),
		.FOSC_OPTION(FOSC_OPTION), .FAST_INTERNAL_OSCILLATOR_SEL(FAST_INTERNAL_OSCILLATOR_SEL),
		.IRQ_ACK(IRQ_ACK), .GLOBAL_IRQ_ENABLE(GLOBAL_IRQ_ENABLE), .ACC(ACC),
		.FLAG_C(FLAG_C), .FLAG_Z(FLAG_Z));
	ict_mem_model mem (
		.PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .CLK(CLK), .DM_ADDR(DM_ADDR),
		.DM_RDATA(DM_RDATA), .DM_WDATA(DM_WDATA), .DM_WE(DM_WE));

	// 250 MHz system clock
	initial begin
		CLK = 1'b0;
		forever #2 CLK = ~CLK;
	end

	// a random acknowledge in mid-cycle drops the global enable before any commit
	task automatic begin_cyc();
		ack_c = (($urandom % 8) == 0);
		if (ack_c != 0) gie = 0;
	endtask

	task automatic end_cyc(input int pm, input int wa, input int wd);
		exp_q.push_back('{acc, cf, zf, gie, pm, wa, wd, ack_c});
	endtask

	// instruction-level model; it stops where the outcome is left open
	task automatic build_trace();
		logic [15:0] w;
		int opd, r, wa, wd, nxt, arg, n, p;
		bit stop;
		exp_q.delete();
		stk.delete();
		acc = 0;
		cf = 0;
		zf = 0;
		gie = 0;
		pc = 0;
		stop = 0;
		begin_cyc();
		end_cyc(1, -1, 0); // bubble after reset fetches word 0
		for (n = 0; n < 40 && !stop; n++) begin
			p = pc;
			w = mdl_pm[p];
			arg = w[7:0];
			opd = (w[15:12] == OP_ALUX) ? arg : mdl_dm[arg];
			wa = -1;
			wd = 0;
			nxt = -1;
			stop = (arg == 2 && w[15:12] inside {OP_ALUM, OP_ROT, OP_BSET, OP_BCLR, OP_SZ, OP_SZB})
				|| (w[15:12] == OP_MOVM && arg == 2 && (p % 256) == 255)
				|| (w[15:12] inside {OP_RET, OP_RETURN_FROM_IRQ_INSTR} && stk.size() == 0)
				|| (w[15:12] == OP_CALL && stk.size() == 8)
				|| (w[15:12] == OP_ROT && w[10]);
			if (!stop) begin
				begin_cyc();
				case (w[15:12])
					OP_MOVX: acc = arg;
					OP_ALUM, OP_ALUX: begin
						case (w[10:8])
							ALU_ADD, ALU_ADC: begin
								r = acc + opd + (w[8] ? cf : 0);
								cf = (r > 255);
							end
							ALU_SUB, ALU_SBC: begin
								r = acc - opd - (w[8] ? cf : 0);
								cf = (r < 0);
							end
							ALU_AND: r = acc & opd;
							ALU_OR: r = acc | opd;
							ALU_XOR: r = acc ^ opd;
							default: r = ~opd;
						endcase
						r = r & 255;
						zf = (r == 0);
						wa = w[F_DEST] ? arg : -1;
						wd = r;
						if (!w[F_DEST]) acc = r;
					end
					OP_MOVM: begin
						wa = arg;
						wd = acc;
					end
					OP_ROT: begin
						case (w[10:8])
							ROTATE_RIGHT: r = (opd >> 1) | ((opd & 1) << 7);
							ROTATE_LEFT: r = (opd << 1) | (opd >> 7);
							ROTATE_RIGHT_THROUGH_CARRY: r = (opd >> 1) | (cf << 7);
							default: r = (opd << 1) | cf;
						endcase
						if (w[9]) cf = w[8] ? (opd >> 7) : (opd & 1);
						r = r & 255;
						wa = w[F_DEST] ? arg : -1;
						wd = r;
						if (!w[F_DEST]) acc = r;
					end
					OP_BSET, OP_BCLR: begin
						wa = arg;
						wd = w[12] ? (opd & ~(1 << w[10:8]) & 255) : (opd | (1 << w[10:8]));
					end
					OP_SZ: if (opd == 0) nxt = (p + 2) % 4096;
					OP_SZB: if (((opd >> w[10:8]) & 1) == 0) nxt = (p + 2) % 4096;
					OP_JMP: nxt = w[11:0];
					OP_CALL: begin
						stk.push_back((p + 1) % 4096);
						nxt = w[11:0];
					end
					OP_RET, OP_RETURN_FROM_IRQ_INSTR: begin
						nxt = stk.pop_back();
						if (w[12]) gie = 1;
					end
					OP_TBRD: nxt = -2;
					default: wa = -1;
				endcase
				if (wa >= 0) mdl_dm[wa] = wd;
				if (wa == 2) nxt = (p & 12'hF00) | wd;
				if (nxt == -2) begin
					end_cyc(w[11:8] * 256 + acc, -1, 0);
					begin_cyc();
					acc = mdl_pm[w[11:8] * 256 + acc][7:0];
					end_cyc(-1, -1, 0);
					pc = (p + 1) % 4096;
				end else if (nxt >= 0) begin
					end_cyc(nxt, wa, wd);
					begin_cyc();
					end_cyc((nxt + 1) % 4096, -1, 0);
					pc = nxt;
				end else begin
					end_cyc((p + 2) % 4096, wa, wd);
					pc = (p + 1) % 4096;
				end
			end
		end
	endtask

	// load fresh memories, reset, then compare every clock against the trace
	task automatic run_prog();
		logic [15:0] w;
		int k, ph;
		@(posedge CLK);
		#1;
		RST_N = 1'b0;
		for (k = 0; k < 4096; k++) begin
			w = 16'($urandom);
			if (w[15:12] inside {OP_MOVX, OP_ALUX}) w[F_DEST] = 1'b0;
			if (w[15:12] == OP_MOVM && ($urandom % 2) != 0) w[7:0] = PROGRAM_COUNTER_LOW_BYTE;
			mdl_pm[k] = w;
			mem.pm[k] = w;
		end
		for (k = 0; k < 256; k++) begin
			mdl_dm[k] = (($urandom % 4) == 0) ? 0 : $urandom % 256;
			mem.dm[k] = mdl_dm[k][7:0];
		end
		build_trace();
		opt = $urandom % 4; // software side assumed to match this choice
		FOSC_OPTION = opt[1:0];
		repeat (6) @(posedge CLK);
		#1;
		RST_N = 1'b1;
		foreach (exp_q[k]) begin
			for (ph = 1; ph <= 4; ph++) begin
				@(posedge CLK);
				#1;
				IRQ_ACK = (ph == 1) && (exp_q[k].ack != 0);
				FOSC_OPTION = 2'($urandom); // later changes must not reach the frozen code
				`CHK(DM_WE, (ph == 3 && exp_q[k].wa >= 0), "write strobe")
				if (ph == 3 && exp_q[k].wa >= 0) begin
					`CHK(DM_ADDR, exp_q[k].wa, "write address")
					`CHK(DM_WDATA, exp_q[k].wd, "write data")
				end
				if (ph == 4) begin
					`CHK(ACC, exp_q[k].acc, "accumulator")
					`CHK(FLAG_C, exp_q[k].c, "carry")
					`CHK(FLAG_Z, exp_q[k].z, "zero")
					`CHK(GLOBAL_IRQ_ENABLE, exp_q[k].g, "global enable")
					`CHK(FAST_INTERNAL_OSCILLATOR_SEL, (opt == 3) ? 0 : opt, "osc code")
					if (exp_q[k].pm >= 0) `CHK(PM_ADDR, exp_q[k].pm, "program address")
				end
			end
		end
	endtask

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("All checks passed");
		end else begin
			$display("Checks failed");
		end
		$finish;
	endtask

	// four batches of random programs, each program after its own reset
	initial begin
		int t;
		RST_N = 1'b0;
		IRQ_ACK = 1'b0;
		FOSC_OPTION = 2'h0;
		void'($urandom(32'h2858));
		for (t = 0; t < 4; t++) begin
			repeat (40) run_prog();
			$display("test %0d done, %0d checks so far", t, checks);
		end
		wrap_up();
	end
endmodule // test_cpu_instruction_timing
